/* File: ext_and_periph_irq_flags.sv */
// Flag, enable and priority logic for three external lines and the first peripheral flags.
//
// The register addresses and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
module ext_and_periph_irq_flags
    import irq_flags_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite slave.
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Event pulses from pins and peripherals.
    input  wire logic        line_one_event,
    input  wire logic        line_two_event,
    input  wire logic        line_three_event,
    input  wire logic        converter_done_event,
    input  wire logic        sync_serial_done_event,
    input  wire logic        timer_two_match_event,
    input  wire logic        timer_one_overflow_event,
    // Buffer levels from the serial port.
    input  wire logic        serial_rx_full,
    input  wire logic        serial_tx_empty,
    // Priority request levels and the summary interrupt.
    output logic             high_irq_req,
    output logic             low_irq_req,
    output logic             irq
);

    // ************************************************************
    // Bus slave state
    // ************************************************************
    logic [7:0] aw_addr_r;
    logic       aw_held_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic       w_held_r;
    logic [7:0] ext_ctrl_r;
    logic [7:0] periph_r;
    logic [1:0] irq_status_r;
    logic [1:0] irq_mask_r;
    logic       wr_fire;
    logic       rd_fire;
    logic [7:0] wr_byte;
    logic       wr_ext;
    logic       wr_periph;
    logic       wr_mask;
    logic       rd_status;
    logic [7:0] periph_view;
    logic       high_nxt;
    logic       low_nxt;

    // A write commits once both halves are held and the old response is gone.
    assign wr_fire = aw_held_r && w_held_r && !s_axi_bvalid;
    assign wr_byte = w_data_r[7:0];
    assign wr_ext = wr_fire && (aw_addr_r == ext_ctrl_addr) && w_strb_r[0];
    assign wr_periph = wr_fire && (aw_addr_r == periph_addr) && w_strb_r[0];
    assign wr_mask = wr_fire && (aw_addr_r == irq_mask_addr) && w_strb_r[0];
    assign rd_fire = s_axi_arvalid && s_axi_arready;
    assign rd_status = rd_fire && (s_axi_araddr == irq_status_addr);

    // Write address channel, taken once and held until commit.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r     <= 1'b0;
            aw_addr_r     <= 8'h00;
            s_axi_awready <= 1'b0;
        end else begin
            s_axi_awready <= !aw_held_r && !s_axi_awready && s_axi_awvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_held_r <= 1'b0;
            end
        end
    end

    // Write data channel, independent of the address so either may come first.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_r     <= 1'b0;
            w_data_r     <= 32'h0000_0000;
            w_strb_r     <= 4'h0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_wready <= !w_held_r && !s_axi_wready && s_axi_wvalid;
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_held_r <= 1'b0;
            end
        end
    end

    // Write response; unmapped addresses answer with a slave error.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= resp_okay;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            case (aw_addr_r)
                ext_ctrl_addr, periph_addr, level_addr,
                irq_status_addr, irq_mask_addr: s_axi_bresp <= resp_okay;
                default: s_axi_bresp <= resp_slverr;
            endcase
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ************************************************************
    // External line control register
    // ************************************************************

    // Set wins over a software clear in the same cycle, so no event is lost.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ext_ctrl_r <= ext_ctrl_reset;
        end else begin
            if (wr_ext) begin
                ext_ctrl_r <= wr_byte;
            end
            // Events set flags regardless of the enables.
            if (line_three_event) begin
                ext_ctrl_r[line_three_flag_bit] <= 1'b1;
            end
            if (line_two_event) begin
                ext_ctrl_r[line_two_flag_bit] <= 1'b1;
            end
            if (line_one_event) begin
                ext_ctrl_r[line_one_flag_bit] <= 1'b1;
            end
        end
    end

    // ************************************************************
    // Peripheral request flags one
    // ************************************************************

    // Only the software-clearable bits are stored; the serial bits are live levels.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            periph_r <= periph_reset;
        end else begin
            if (wr_periph) begin
                periph_r <= wr_byte & periph_sw_mask;
            end
            if (converter_done_event) begin
                periph_r[converter_done_bit] <= 1'b1;
            end
            if (sync_serial_done_event) begin
                periph_r[sync_serial_bit] <= 1'b1;
            end
            if (timer_two_match_event) begin
                periph_r[timer_two_bit] <= 1'b1;
            end
            if (timer_one_overflow_event) begin
                periph_r[timer_one_bit] <= 1'b1;
            end
        end
    end

    // Serial flags follow the buffer state, which the port itself clears on access.
    always_comb begin
        periph_view = periph_r;
        periph_view[serial_rx_full_bit]  = serial_rx_full;
        periph_view[serial_tx_empty_bit] = serial_tx_empty;
    end

    // ************************************************************
    // Priority request levels
    // ************************************************************

    // Line three carries no priority bit here, so it requests at high level.
    always_comb begin
        high_nxt = 1'b0;
        low_nxt  = 1'b0;
        if (ext_ctrl_r[line_one_flag_bit] && ext_ctrl_r[line_one_enable_bit]) begin
            if (ext_ctrl_r[line_one_priority_bit]) begin
                high_nxt = 1'b1;
            end else begin
                low_nxt = 1'b1;
            end
        end
        if (ext_ctrl_r[line_two_flag_bit] && ext_ctrl_r[line_two_enable_bit]) begin
            if (ext_ctrl_r[line_two_priority_bit]) begin
                high_nxt = 1'b1;
            end else begin
                low_nxt = 1'b1;
            end
        end
        if (ext_ctrl_r[line_three_flag_bit] && ext_ctrl_r[line_three_enable_bit]) begin
            high_nxt = 1'b1;
        end
    end

    // Request outputs are registered, one cycle behind the flags.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            high_irq_req <= 1'b0;
            low_irq_req  <= 1'b0;
        end else begin
            high_irq_req <= high_nxt;
            low_irq_req  <= low_nxt;
        end
    end

    // ************************************************************
    // Interrupt status, mask and output
    // ************************************************************

    // Status is sticky on request edges-as-levels; a read clears, a new set wins.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_status_r <= irq_reset;
        end else begin
            irq_status_r <= (rd_status ? 2'h0 : irq_status_r) | {low_nxt, high_nxt};
        end
    end

    // Mask register: a one lets the status bit through.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_mask_r <= irq_reset;
        end else if (wr_mask) begin
            irq_mask_r <= wr_byte[1:0];
        end
    end

    // Registered summary output.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status_r & irq_mask_r);
        end
    end

    // ************************************************************
    // Read channel
    // ************************************************************

    // One read at a time; the answer comes one cycle after the address is taken.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= resp_okay;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (rd_fire) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= resp_okay;
                case (s_axi_araddr)
                    ext_ctrl_addr:   s_axi_rdata <= {24'h000000, ext_ctrl_r};
                    periph_addr:     s_axi_rdata <= {24'h000000, periph_view};
                    level_addr:      s_axi_rdata <= {30'h0, low_irq_req, high_irq_req};
                    irq_status_addr: s_axi_rdata <= {30'h0, irq_status_r};
                    irq_mask_addr:   s_axi_rdata <= {30'h0, irq_mask_r};
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= resp_slverr;
                    end
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************

    sequence line_one_hit;
        line_one_event;
    endsequence

    a_line_one_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
        line_one_hit |=> ext_ctrl_r[line_one_flag_bit])
        else $error("line one flag not set after event");

    a_line_two_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
        line_two_event |=> ext_ctrl_r[line_two_flag_bit])
        else $error("line two flag not set after event");

    a_line_three_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        ext_ctrl_r[line_three_flag_bit] && !wr_ext |=> ext_ctrl_r[line_three_flag_bit])
        else $error("line three flag dropped without software clear");

    a_unimpl_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        !periph_view[7] && !periph_view[2])
        else $error("unimplemented peripheral bit reads one");

    a_converter_set: assert property (@(posedge aclk) disable iff (!aresetn)
        converter_done_event |=> periph_r[converter_done_bit])
        else $error("converter flag not set");

    // The serial bits are checked where software sees them, in the read answer.
    a_rx_mirror: assert property (@(posedge aclk) disable iff (!aresetn)
        rd_fire && (s_axi_araddr == periph_addr)
        |=> s_axi_rdata[serial_rx_full_bit] == $past(serial_rx_full))
        else $error("receive flag does not follow buffer");

    a_tx_mirror: assert property (@(posedge aclk) disable iff (!aresetn)
        rd_fire && (s_axi_araddr == periph_addr)
        |=> s_axi_rdata[serial_tx_empty_bit] == $past(serial_tx_empty))
        else $error("transmit flag does not follow buffer");

    a_timer_flags: assert property (@(posedge aclk) disable iff (!aresetn)
        timer_two_match_event ##1 1'b1 |-> periph_r[timer_two_bit])
        else $error("timer two flag not set");

    a_overflow_flag: assert property (@(posedge aclk) disable iff (!aresetn)
        timer_one_overflow_event |=> periph_r[timer_one_bit])
        else $error("timer one flag not set");

    a_high_request: assert property (@(posedge aclk) disable iff (!aresetn)
        ext_ctrl_r[line_one_flag_bit] && ext_ctrl_r[line_one_enable_bit]
        && ext_ctrl_r[line_one_priority_bit] |=> high_irq_req)
        else $error("high request missing for enabled line one");

    a_no_request: assert property (@(posedge aclk) disable iff (!aresetn)
        !(|(ext_ctrl_r[2:0] & ext_ctrl_r[5:3])) |=> !high_irq_req && !low_irq_req)
        else $error("request raised without flag and enable");

    // A read of the status clears a bit unless its request is still pending.
    a_status_clear: assert property (@(posedge aclk) disable iff (!aresetn)
        rd_status && !high_nxt |=> !irq_status_r[0])
        else $error("status bit survived a clearing read");

    // An unmasked status bit must reach the summary output one cycle later.
    a_irq_follows: assert property (@(posedge aclk) disable iff (!aresetn)
        (|(irq_status_r & irq_mask_r)) |=> irq)
        else $error("summary interrupt missing for unmasked status");

endmodule

/* File: irq_flags_pkg.sv */
// Package with register map, field positions and reset values of the flag block.
package irq_flags_pkg;

    // ************************************************************
    // Register byte addresses
    // ************************************************************
    localparam logic [7:0] ext_ctrl_addr   = 8'h00;
    localparam logic [7:0] periph_addr     = 8'h04;
    localparam logic [7:0] level_addr      = 8'h08;
    localparam logic [7:0] irq_status_addr = 8'h0c;
    localparam logic [7:0] irq_mask_addr   = 8'h10;

    // ************************************************************
    // External line control fields
    // ************************************************************
    localparam int line_two_priority_bit = 7;
    localparam int line_one_priority_bit = 6;
    localparam int line_three_enable_bit = 5;
    localparam int line_two_enable_bit   = 4;
    localparam int line_one_enable_bit   = 3;
    localparam int line_three_flag_bit   = 2;
    localparam int line_two_flag_bit     = 1;
    localparam int line_one_flag_bit     = 0;
    localparam logic [7:0] ext_ctrl_reset = 8'hc0;

    // ************************************************************
    // Peripheral flag fields
    // ************************************************************
    localparam int converter_done_bit = 6;
    localparam int serial_rx_full_bit = 5;
    localparam int serial_tx_empty_bit = 4;
    localparam int sync_serial_bit    = 3;
    localparam int timer_two_bit      = 1;
    localparam int timer_one_bit      = 0;
    localparam logic [7:0] periph_sw_mask  = 8'h4b;
    localparam logic [7:0] periph_reset    = 8'h00;

    // Interrupt status layout: bit 0 high request, bit 1 low request.
    localparam logic [1:0] irq_reset = 2'h0;

    // AXI response codes.
    localparam logic [1:0] resp_okay   = 2'h0;
    localparam logic [1:0] resp_slverr = 2'h2;

endpackage

/* File: periph_model.sv */
// Behavioural model of the pins and peripherals that raise events.
`timescale 1ns/1ps
module periph_model (
    input  wire logic       aclk,
    input  wire logic [6:0] fire,
    input  wire logic       rx_level,
    input  wire logic       tx_level,
    output logic      [6:0] events,
    output logic            serial_rx_full,
    output logic            serial_tx_empty
);
    // A request held for one cycle leaves as a one-cycle pulse, as a completed event does.
    always_ff @(posedge aclk) begin
        events <= fire;
    end

    // Buffer levels follow the clock, so the block never sees them change mid-cycle.
    always_ff @(posedge aclk) begin
        serial_rx_full  <= rx_level;
        serial_tx_empty <= tx_level;
    end
endmodule

/* File: testbench.sv */
// Self-checking testbench of the external line and peripheral flag block.
`timescale 1ns/1ps
module testbench
    import irq_flags_pkg::*;
;
    typedef struct {int ev; logic [7:0] addr; logic [7:0] set_v; logic [7:0] base;} row_t;
    typedef struct {int ev; logic [7:0] en_v; logic [7:0] lo_v; logic [1:0] lo_req;} prio_t;

    logic        aclk = 1'b0;
    logic        aresetn;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0]  s_axi_wstrb;
    logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic [6:0]  fire, events;
    logic        rx_level, tx_level, serial_rx_full, serial_tx_empty;
    logic        high_irq_req, low_irq_req, irq;
    int          err_count = 0;
    int          checks_done = 0;

    // Event rows: which source fires, where its flag shows, and the value after clearing.
    row_t rows[7] = '{
        '{0, 8'h00, 8'hc1, 8'hc0},
        '{1, 8'h00, 8'hc2, 8'hc0},
        '{2, 8'h00, 8'hc4, 8'hc0},
        '{3, 8'h04, 8'h40, 8'h00},
        '{4, 8'h04, 8'h08, 8'h00},
        '{5, 8'h04, 8'h02, 8'h00},
        '{6, 8'h04, 8'h01, 8'h00}};
    // Priority rows: enable at high priority, then drop the line's priority bit keeping the flag; line three has none and stays high.
    prio_t prows[3] = '{
        '{0, 8'hc8, 8'h89, 2'h1},
        '{1, 8'hd0, 8'h52, 2'h1},
        '{2, 8'he0, 8'h24, 2'h2}};

    // The clock toggles every half period of 4 ns.
    always #4 aclk = ~aclk;

    periph_model peer (.aclk, .fire, .rx_level, .tx_level, .events, .serial_rx_full,
                       .serial_tx_empty);

    ext_and_periph_irq_flags DUT (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .line_one_event(events[0]), .line_two_event(events[1]),
        .line_three_event(events[2]), .converter_done_event(events[3]),
        .sync_serial_done_event(events[4]), .timer_two_match_event(events[5]),
        .timer_one_overflow_event(events[6]), .serial_rx_full, .serial_tx_empty,
        .high_irq_req, .low_irq_req, .irq);

    // ************************************************************
    // Helpers
    // ************************************************************
    task automatic finish_test();
        $display("Checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            $display("Error %s expected %h seen %h", name, exp, seen);
            err_count++;
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
    endtask

    // A silent slave must not hang the run, so every bus wait is bounded here.
    task automatic guard(input int n);
        if (n > 200) begin
            $display("Error bus answer expected within 200 cycles seen none");
            err_count++;
            finish_test();
        end
    endtask

    task automatic bus_write(input logic [7:0] a, input logic [7:0] v, output logic [1:0] rs);
        logic aw_ok;
        logic w_ok;
        int   n;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h000000, v};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            guard(++n);
            if (!aw_ok && s_axi_awready === 1'b1) begin
                aw_ok = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_ok && s_axi_wready === 1'b1) begin
                w_ok = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do begin
            @(posedge aclk);
            guard(++n);
        end while (s_axi_bvalid !== 1'b1);
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic bus_read(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
        int n;
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            guard(++n);
        end while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        while (s_axi_rvalid !== 1'b1) begin
            @(posedge aclk);
            guard(++n);
        end
        v = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
        bus_read(a, d, r);
        check(name, d, exp);
    endtask

    task automatic fire_event(input int idx);
        fire <= 7'h01 << idx;
        @(posedge aclk);
        fire <= 7'h00;
        tick(6);
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        aresetn <= 1'b0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= '0;
        s_axi_wstrb <= 4'hf;
        fire <= 7'h00;
        rx_level <= 1'b0;
        tx_level <= 1'b0;
        tick(16);
        aresetn <= 1'b1;
        tick(2);
        rd_chk("ext reset", ext_ctrl_addr, 32'hc0);
        rd_chk("periph reset", periph_addr, 32'h00);
        rd_chk("mask reset", irq_mask_addr, 32'h00);
        $display("Test reset done");
        // Flags set with every enable off, stay set, and clear only by software.
        foreach (rows[i]) begin
            fire_event(rows[i].ev);
            rd_chk("flag set", rows[i].addr, {24'h0, rows[i].set_v});
            rd_chk("flag sticky", rows[i].addr, {24'h0, rows[i].set_v});
            check("no request", {30'h0, high_irq_req, low_irq_req}, 32'h0);
            bus_write(rows[i].addr, rows[i].base, r);
            rd_chk("flag clear", rows[i].addr, {24'h0, rows[i].base});
        end
        $display("Test flags done");
        bus_write(irq_mask_addr, 8'h03, r);
        foreach (prows[i]) begin
            bus_write(ext_ctrl_addr, prows[i].en_v, r);
            fire_event(prows[i].ev);
            check("high req", {30'h0, high_irq_req, low_irq_req}, 32'h2);
            check("irq", {31'h0, irq}, 32'h1);
            bus_write(ext_ctrl_addr, prows[i].lo_v, r);
            tick(3);
            check("moved req", {30'h0, high_irq_req, low_irq_req}, {30'h0, prows[i].lo_req});
            bus_write(ext_ctrl_addr, 8'hc0, r);
            tick(3);
            check("req gone", {30'h0, high_irq_req, low_irq_req}, 32'h0);
        end
        $display("Test priority done");
        // Status keeps both levels seen, clears on read, and the mask gates the output.
        rd_chk("status sticky", irq_status_addr, 32'h3);
        rd_chk("status cleared", irq_status_addr, 32'h0);
        bus_write(irq_mask_addr, 8'h01, r);
        bus_write(ext_ctrl_addr, 8'h52, r);
        tick(4);
        check("irq masked", {31'h0, irq}, 32'h0);
        rd_chk("level", level_addr, 32'h2);
        rd_chk("status low", irq_status_addr, 32'h2);
        bus_write(irq_mask_addr, 8'h03, r);
        tick(4);
        check("irq unmasked", {31'h0, irq}, 32'h1);
        bus_write(ext_ctrl_addr, 8'hc0, r);
        tick(3);
        bus_read(irq_status_addr, d, r);
        rd_chk("status empty", irq_status_addr, 32'h0);
        tick(3);
        check("irq idle", {31'h0, irq}, 32'h0);
        $display("Test interrupt done");
        // Reserved and read-only bits ignore writes; serial bits follow the buffers.
        bus_write(periph_addr, 8'hff, r);
        check("write resp", {30'h0, r}, 32'h0);
        rd_chk("periph ro", periph_addr, 32'h4b);
        rx_level <= 1'b1;
        tx_level <= 1'b1;
        tick(3);
        rd_chk("serial set", periph_addr, 32'h7b);
        bus_write(periph_addr, 8'h00, r);
        rd_chk("serial stay", periph_addr, 32'h30);
        rx_level <= 1'b0;
        tx_level <= 1'b0;
        tick(3);
        rd_chk("serial gone", periph_addr, 32'h00);
        $display("Test serial done");
        bus_read(8'h20, d, r);
        check("unmapped rdata", d, 32'h0);
        check("unmapped rresp", {30'h0, r}, 32'h2);
        bus_write(8'h20, 8'hff, r);
        check("unmapped bresp", {30'h0, r}, 32'h2);
        // A write with byte lane zero disabled stores nothing; status ignores writes.
        s_axi_wstrb <= 4'h0;
        bus_write(irq_mask_addr, 8'h00, r);
        s_axi_wstrb <= 4'hf;
        rd_chk("strobe off", irq_mask_addr, 32'h3);
        bus_write(irq_status_addr, 8'h03, r);
        check("status wr resp", {30'h0, r}, 32'h0);
        rd_chk("status ro", irq_status_addr, 32'h0);
        $display("Test unmapped done");
        finish_test();
    end
endmodule
